// file: include/sale_pkg.sv
// What this block does
// - Four alarm lines, any channels per line
// - One line and one limit set per channel
// - Violating scan reading pulses selected alarm line
// - Scanned non-digital alarm goes to store and queue
// - Non-scanned alarms go to queue only
// - Window mode: above upper or below lower
// - Upper mode: value or count above upper
// - Lower mode: value below lower limit
// - Disabled suppresses; counter/digital restrict modes
// - Counter upper limit is unsigned 32-bit
// - Window write with upper below lower rejected
// - Digital pattern equal or not-equal alarms
// - Pattern wider than channel width rejected
// - Masked pattern bits are not compared
// - Measurement change or scaling clears alarm
// - Scan removal pauses multiplexer evaluation, keeps limits
// - Counter and digital evaluate outside scan list
// - External-meter channels: connection and delay only
`default_nettype none
package sale_pkg;

  localparam int ALARM_LINES = 4;
  localparam int LINE_W = 2;
  localparam int DATA_W = 32;

  typedef enum logic [1:0] {
    SALE_KIND_MUX = 2'h0,
    SALE_KIND_COUNTER = 2'h1,
    SALE_KIND_DIGITAL = 2'h2
  } sale_kind_t;

  typedef enum logic [2:0] {
    SALE_MODE_NONE = 3'h0,
    SALE_MODE_WINDOW = 3'h1,
    SALE_MODE_UPPER = 3'h2,
    SALE_MODE_LOWER = 3'h3,
    SALE_MODE_ON = 3'h4
  } sale_mode_t;

  typedef enum logic [1:0] {
    SALE_WIDTH_8 = 2'h0,
    SALE_WIDTH_16 = 2'h1,
    SALE_WIDTH_32 = 2'h2
  } sale_width_t;

  typedef enum logic {
    SALE_COND_NOT_PATTERN = 1'b0,
    SALE_COND_PATTERN = 1'b1
  } sale_cond_t;

  localparam logic [DATA_W-1:0] SALE_MASK_8 = 32'h0000_00FF;
  localparam logic [DATA_W-1:0] SALE_MASK_16 = 32'h0000_FFFF;
  localparam logic [DATA_W-1:0] SALE_MASK_32 = 32'hFFFF_FFFF;
  localparam logic [DATA_W-1:0] SALE_ZERO = 32'h0000_0000;

  // One channel's alarm setup; mask bits set mean don't-care
  typedef struct packed {
    sale_kind_t kind;
    sale_width_t width;
    sale_mode_t mode;
    logic [LINE_W-1:0] line;
    sale_cond_t cond;
    logic [DATA_W-1:0] upper;
    logic [DATA_W-1:0] lower;
    logic [DATA_W-1:0] pattern;
    logic [DATA_W-1:0] mask;
  } sale_entry_t;

  localparam sale_entry_t SALE_ENTRY_RESET = '0;

  // Bits that a digital channel of the given width really carries
  function automatic logic [DATA_W-1:0] width_mask(input sale_width_t w);
    case (w)
      SALE_WIDTH_8: width_mask = SALE_MASK_8;
      SALE_WIDTH_16: width_mask = SALE_MASK_16;
      default: width_mask = SALE_MASK_32;
    endcase
  endfunction

endpackage
`default_nettype wire

// file: include/sale_unit_if.sv
`timescale 1ns/10ps
`default_nettype none
// Carries one channel entry and a value to a judging unit
interface sale_unit_if;
  sale_pkg::sale_entry_t ent;
  logic [sale_pkg::DATA_W-1:0] val;
  logic verdict;
  modport core (output ent, output val, input verdict);
  modport unit (input ent, input val, output verdict);
endinterface
`default_nettype wire

// file: design/sale_limit_cmp.sv
`timescale 1ns/10ps
`default_nettype none
module sale_limit_cmp (
  sale_unit_if.unit u
);

  logic [sale_pkg::DATA_W-1:0] care;
  logic patMatch;

  // Only unmasked bits inside the channel width take part
  assign care = ~u.ent.mask & sale_pkg::width_mask(u.ent.width);
  assign patMatch = ((u.val ^ u.ent.pattern) & care) == sale_pkg::SALE_ZERO;

  // Verdict per channel kind; unsupported modes never alarm
  always_comb
  begin
    u.verdict = 1'b0;
    case (u.ent.kind)
      sale_pkg::SALE_KIND_COUNTER:
        u.verdict = (u.ent.mode == sale_pkg::SALE_MODE_UPPER) && (u.val > u.ent.upper);
      sale_pkg::SALE_KIND_DIGITAL:
        u.verdict = (u.ent.mode == sale_pkg::SALE_MODE_ON) &&
                    ((u.ent.cond == sale_pkg::SALE_COND_PATTERN) ? patMatch : !patMatch);
      sale_pkg::SALE_KIND_MUX:
        case (u.ent.mode)
          sale_pkg::SALE_MODE_WINDOW:
            u.verdict = ($signed(u.val) > $signed(u.ent.upper)) ||
                        ($signed(u.val) < $signed(u.ent.lower));
          sale_pkg::SALE_MODE_UPPER:
            u.verdict = $signed(u.val) > $signed(u.ent.upper);
          sale_pkg::SALE_MODE_LOWER:
            u.verdict = $signed(u.val) < $signed(u.ent.lower);
          default:
            u.verdict = 1'b0;
        endcase
      default:
        u.verdict = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// file: design/sale_cfg_check.sv
`timescale 1ns/10ps
`default_nettype none
module sale_cfg_check (
  sale_unit_if.unit u
);

  // Verdict high means the candidate setup is refused; val is the raw pattern
  always_comb
  begin
    u.verdict = 1'b0;
    case (u.ent.kind)
      sale_pkg::SALE_KIND_MUX:
        u.verdict = (u.ent.mode == sale_pkg::SALE_MODE_ON) ||
                    ((u.ent.mode == sale_pkg::SALE_MODE_WINDOW) &&
                     ($signed(u.ent.upper) < $signed(u.ent.lower)));
      sale_pkg::SALE_KIND_COUNTER:
        u.verdict = !((u.ent.mode == sale_pkg::SALE_MODE_NONE) ||
                      (u.ent.mode == sale_pkg::SALE_MODE_UPPER));
      sale_pkg::SALE_KIND_DIGITAL:
        u.verdict = !((u.ent.mode == sale_pkg::SALE_MODE_NONE) ||
                      (u.ent.mode == sale_pkg::SALE_MODE_ON)) ||
                    ((u.val & ~sale_pkg::width_mask(u.ent.width)) != sale_pkg::SALE_ZERO);
      default:
        u.verdict = 1'b1;
    endcase
  end

endmodule
`default_nettype wire

// file: design/sale_evaluator.sv
`timescale 1ns/10ps
`default_nettype none
module sale_evaluator #(
  parameter int NUM_CH = 8,
  parameter int DELAY_W = 16,
  localparam int CW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Measurement setup of one channel
  input wire logic measWrite,
  input wire logic [CW-1:0] measChan,
  input wire sale_pkg::sale_kind_t measKind,
  input wire sale_pkg::sale_width_t measWidth,
  input wire logic measExternal,
  input wire logic measFourWire,
  input wire logic [DELAY_W-1:0] measDelay,
  input wire logic scaleEnable,
  input wire logic [CW-1:0] scaleChan,
  // Alarm setup of one channel
  input wire logic alarmWrite,
  input wire logic [CW-1:0] alarmChan,
  input wire sale_pkg::sale_mode_t alarmMode,
  input wire logic [sale_pkg::LINE_W-1:0] alarmLineSel,
  input wire sale_pkg::sale_cond_t alarmCond,
  input wire logic [sale_pkg::DATA_W-1:0] alarmUpper,
  input wire logic [sale_pkg::DATA_W-1:0] alarmLower,
  input wire logic [sale_pkg::DATA_W-1:0] alarmPattern,
  input wire logic [sale_pkg::DATA_W-1:0] alarmMask,
  // Scan list membership
  input wire logic scanAdd,
  input wire logic scanRemove,
  input wire logic [CW-1:0] scanChan,
  // Readings from the sequencer
  input wire logic rdValid,
  input wire logic [CW-1:0] rdChan,
  input wire logic [sale_pkg::DATA_W-1:0] rdValue,
  input wire logic rdScanned,
  input wire logic [CW-1:0] seqChan,
  // Results
  output logic [sale_pkg::ALARM_LINES-1:0] alarmLine,
  output logic storeWrite,
  output logic queueWrite,
  output logic [CW-1:0] eventChan,
  output logic [sale_pkg::DATA_W-1:0] eventValue,
  output logic [sale_pkg::LINE_W-1:0] eventLine,
  output logic cfgAccept,
  output logic cfgError,
  output logic connFourWire,
  output logic [DELAY_W-1:0] connDelay,
  output logic [NUM_CH-1:0] inScanMap
);

  typedef struct packed {
    sale_pkg::sale_entry_t [NUM_CH-1:0] tbl;
    logic [NUM_CH-1:0] inScan;
    logic [NUM_CH-1:0] external;
    logic [NUM_CH-1:0] fourWire;
    logic [NUM_CH-1:0][DELAY_W-1:0] delay;
    logic [sale_pkg::ALARM_LINES-1:0] alarmLine;
    logic storeWrite;
    logic queueWrite;
    logic [CW-1:0] eventChan;
    logic [sale_pkg::DATA_W-1:0] eventValue;
    logic [sale_pkg::LINE_W-1:0] eventLine;
    logic cfgAccept;
    logic cfgError;
    logic connFourWire;
    logic [DELAY_W-1:0] connDelay;
  } sale_state_t;

  sale_state_t st;
  sale_state_t next_st;
  sale_pkg::sale_entry_t rdEntry;
  sale_pkg::sale_entry_t cand;
  logic eligible;
  logic hit;
  logic reject;
  logic [sale_pkg::LINE_W-1:0] curLine;

  sale_unit_if evalBus ();
  sale_unit_if chkBus ();

  // Reading is judged against the entry as it stood before any write this cycle
  assign rdEntry = st.tbl[rdChan];
  assign evalBus.ent = rdEntry;
  assign evalBus.val = rdValue;
  assign curLine = rdEntry.line;

  sale_limit_cmp u_cmp (
    .u(evalBus.unit)
  );

  // Candidate setup keeps the channel's kind and width from its measurement setup
  always_comb
  begin
    cand = st.tbl[alarmChan];
    cand.mode = alarmMode;
    cand.line = alarmLineSel;
    cand.cond = alarmCond;
    cand.upper = alarmUpper;
    cand.lower = alarmLower;
    cand.pattern = alarmPattern & sale_pkg::width_mask(cand.width);
    cand.mask = alarmMask;
  end

  assign chkBus.ent = cand;
  assign chkBus.val = alarmPattern;

  sale_cfg_check u_chk (
    .u(chkBus.unit)
  );

  // External-meter channels carry no alarm setup at all
  assign reject = chkBus.verdict || st.external[alarmChan];

  // Non-external channels only: multiplexer while listed, counter and digital always
  assign eligible = rdValid && !st.external[rdChan] &&
                    (st.inScan[rdChan] || (rdEntry.kind != sale_pkg::SALE_KIND_MUX));
  assign hit = eligible && evalBus.verdict;

  // Next state: setup writes, scan list, one evaluation per reading
  always_comb
  begin
    next_st = st;
    next_st.alarmLine = '0;
    next_st.storeWrite = 1'b0;
    next_st.queueWrite = 1'b0;
    next_st.cfgAccept = 1'b0;
    next_st.cfgError = 1'b0;
    if (hit)
    begin
      next_st.alarmLine[rdEntry.line] = 1'b1;
      next_st.queueWrite = 1'b1;
      next_st.storeWrite = rdScanned && (rdEntry.kind != sale_pkg::SALE_KIND_DIGITAL);
      next_st.eventChan = rdChan;
      next_st.eventValue = rdValue;
      next_st.eventLine = rdEntry.line;
    end
    // Refused setup leaves the old entry untouched
    if (alarmWrite)
    begin
      if (reject)
      begin
        next_st.cfgError = 1'b1;
      end
      else
      begin
        next_st.tbl[alarmChan] = cand;
        next_st.cfgAccept = 1'b1;
      end
    end
    // Removal only clears membership, so the limits come back on re-add
    if (scanRemove)
    begin
      next_st.inScan[scanChan] = 1'b0;
    end
    if (scanAdd)
    begin
      next_st.inScan[scanChan] = 1'b1;
    end
    // Scaling and measurement changes win over an alarm write in the same cycle
    if (scaleEnable)
    begin
      next_st.tbl[scaleChan].mode = sale_pkg::SALE_MODE_NONE;
      next_st.tbl[scaleChan].upper = sale_pkg::SALE_ZERO;
      next_st.tbl[scaleChan].lower = sale_pkg::SALE_ZERO;
      next_st.tbl[scaleChan].pattern = sale_pkg::SALE_ZERO;
      next_st.tbl[scaleChan].mask = sale_pkg::SALE_ZERO;
    end
    if (measWrite)
    begin
      next_st.tbl[measChan] = sale_pkg::SALE_ENTRY_RESET;
      next_st.tbl[measChan].kind = measKind;
      next_st.tbl[measChan].width = measWidth;
      next_st.external[measChan] = measExternal;
      next_st.fourWire[measChan] = measFourWire;
      next_st.delay[measChan] = measDelay;
    end
    next_st.connFourWire = st.fourWire[seqChan];
    next_st.connDelay = st.delay[seqChan];
  end

  // Whole state registered in one place
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign alarmLine = st.alarmLine;
  assign storeWrite = st.storeWrite;
  assign queueWrite = st.queueWrite;
  assign eventChan = st.eventChan;
  assign eventValue = st.eventValue;
  assign eventLine = st.eventLine;
  assign cfgAccept = st.cfgAccept;
  assign cfgError = st.cfgError;
  assign connFourWire = st.connFourWire;
  assign connDelay = st.connDelay;
  assign inScanMap = st.inScan;

  // Checks on the outputs against their causes one cycle earlier
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_mux_read(sale_pkg::sale_mode_t m);
    eligible && (rdEntry.kind == sale_pkg::SALE_KIND_MUX) && (rdEntry.mode == m);
  endsequence

  sequence s_alarm_out;
    queueWrite && alarmLine[$past(curLine)] && (eventLine == $past(curLine));
  endsequence

  property p_line_onehot;
    $onehot0(alarmLine) && (queueWrite == (|alarmLine));
  endproperty
  a_line_onehot: assert property (p_line_onehot) else $error("alarm line not one-hot or unpaired");

  property p_window;
    s_mux_read(sale_pkg::SALE_MODE_WINDOW) ##0
      (($signed(rdValue) > $signed(rdEntry.upper)) || ($signed(rdValue) < $signed(rdEntry.lower)))
      |=> s_alarm_out;
  endproperty
  a_window: assert property (p_window) else $error("window violation not reported");

  property p_upper;
    s_mux_read(sale_pkg::SALE_MODE_UPPER) ##0 ($signed(rdValue) > $signed(rdEntry.upper)) |=> s_alarm_out;
  endproperty
  a_upper: assert property (p_upper) else $error("upper violation not reported");

  property p_lower;
    s_mux_read(sale_pkg::SALE_MODE_LOWER) ##0 ($signed(rdValue) >= $signed(rdEntry.lower)) |=> !queueWrite;
  endproperty
  a_lower: assert property (p_lower) else $error("lower mode alarmed without violation");

  property p_disabled;
    rdValid && (rdEntry.mode == sale_pkg::SALE_MODE_NONE) |=> !queueWrite && (alarmLine == '0);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled channel raised an alarm");

  property p_counter;
    eligible && (rdEntry.kind == sale_pkg::SALE_KIND_COUNTER) &&
      (rdEntry.mode == sale_pkg::SALE_MODE_UPPER) && (rdValue > rdEntry.upper) |=> s_alarm_out;
  endproperty
  a_counter: assert property (p_counter) else $error("count above limit not reported");

  property p_window_reject;
    alarmWrite && (st.tbl[alarmChan].kind == sale_pkg::SALE_KIND_MUX) &&
      (alarmMode == sale_pkg::SALE_MODE_WINDOW) && ($signed(alarmUpper) < $signed(alarmLower))
      |=> cfgError && !cfgAccept;
  endproperty
  a_window_reject: assert property (p_window_reject) else $error("inverted window accepted");

  property p_scan_store;
    rdScanned && hit && (rdEntry.kind != sale_pkg::SALE_KIND_DIGITAL) |=> storeWrite && queueWrite;
  endproperty
  a_scan_store: assert property (p_scan_store) else $error("scanned alarm not stored twice");

  property p_queue_only;
    rdValid && (!rdScanned || (rdEntry.kind == sale_pkg::SALE_KIND_DIGITAL)) |=> !storeWrite;
  endproperty
  a_queue_only: assert property (p_queue_only) else $error("non-scanned alarm reached the store");

  property p_meas_clear;
    measWrite |=> (st.tbl[$past(measChan)].mode == sale_pkg::SALE_MODE_NONE) &&
                  (st.tbl[$past(measChan)].upper == sale_pkg::SALE_ZERO);
  endproperty
  a_meas_clear: assert property (p_meas_clear) else $error("measurement change kept alarm setup");

  property p_unlisted;
    rdValid && !st.inScan[rdChan] && (rdEntry.kind == sale_pkg::SALE_KIND_MUX) |=> !queueWrite;
  endproperty
  a_unlisted: assert property (p_unlisted) else $error("unlisted channel evaluated");

  property p_external;
    rdValid && st.external[rdChan] |=> !queueWrite;
  endproperty
  a_external: assert property (p_external) else $error("external-meter channel evaluated");

  property p_once;
    !rdValid |=> !queueWrite && !storeWrite;
  endproperty
  a_once: assert property (p_once) else $error("alarm without a reading");

  sequence s_dig_read(sale_pkg::sale_cond_t c);
    eligible && (rdEntry.kind == sale_pkg::SALE_KIND_DIGITAL) && (rdEntry.mode == sale_pkg::SALE_MODE_ON) &&
      (rdEntry.cond == c);
  endsequence

  // Restated from the pattern rule, not taken from the compare unit
  sequence s_dig_match;
    ((rdValue ^ rdEntry.pattern) & ~rdEntry.mask & sale_pkg::width_mask(rdEntry.width)) == sale_pkg::SALE_ZERO;
  endsequence

  property p_pattern_hit;
    s_dig_read(sale_pkg::SALE_COND_PATTERN) ##0 s_dig_match |=> s_alarm_out;
  endproperty
  a_pattern_hit: assert property (p_pattern_hit) else $error("digital pattern match not reported");

  property p_not_pattern_quiet;
    s_dig_read(sale_pkg::SALE_COND_NOT_PATTERN) ##0 s_dig_match |=> !queueWrite;
  endproperty
  a_not_pattern_quiet: assert property (p_not_pattern_quiet) else $error("not-pattern alarmed on match");

  property p_width_reject;
    alarmWrite && (st.tbl[alarmChan].kind == sale_pkg::SALE_KIND_DIGITAL) &&
      ((alarmPattern & ~sale_pkg::width_mask(st.tbl[alarmChan].width)) != sale_pkg::SALE_ZERO)
      |=> cfgError && !cfgAccept;
  endproperty
  a_width_reject: assert property (p_width_reject) else $error("over-wide pattern accepted");

  // Counter channel kept out of the scan list must still alarm
  property p_free_eval;
    rdValid && !st.inScan[rdChan] && !st.external[rdChan] && (rdEntry.kind == sale_pkg::SALE_KIND_COUNTER) &&
      (rdEntry.mode == sale_pkg::SALE_MODE_UPPER) && (rdValue > rdEntry.upper) |=> s_alarm_out;
  endproperty
  a_free_eval: assert property (p_free_eval) else $error("unlisted counter channel not evaluated");

  property p_line_store;
    alarmWrite && !reject && !(measWrite && (measChan == alarmChan)) |=>
      cfgAccept && (st.tbl[$past(alarmChan)].line == $past(alarmLineSel));
  endproperty
  a_line_store: assert property (p_line_store) else $error("accepted setup lost its alarm line");

  property p_cfg_answer;
    ((cfgAccept || cfgError) == $past(alarmWrite)) && !(cfgAccept && cfgError);
  endproperty
  a_cfg_answer: assert property (p_cfg_answer) else $error("setup write not answered exactly once");

  property p_scale_clear;
    scaleEnable |=> (st.tbl[$past(scaleChan)].mode == sale_pkg::SALE_MODE_NONE) &&
                    (st.tbl[$past(scaleChan)].upper == sale_pkg::SALE_ZERO) &&
                    (st.tbl[$past(scaleChan)].lower == sale_pkg::SALE_ZERO);
  endproperty
  a_scale_clear: assert property (p_scale_clear) else $error("scaling kept alarm limits");

  // Limits must survive a removal so that re-adding restores them
  property p_remove_keeps;
    scanRemove && !scanAdd && !measWrite && !scaleEnable && !alarmWrite |=>
      (st.tbl == $past(st.tbl)) && !inScanMap[$past(scanChan)];
  endproperty
  a_remove_keeps: assert property (p_remove_keeps) else $error("scan removal touched limits");

endmodule
`default_nettype wire

// file: testbench/sale_seq_model.sv
`timescale 1ns/10ps
`default_nettype none
// Sequencer stand-in: one reading per send, value and channel scrambled while idle
module sale_seq_model (
  input wire logic clk_sys,
  output logic rdValid,
  output logic [2:0] rdChan,
  output logic [31:0] rdValue,
  output logic rdScanned,
  output logic [2:0] seqChan
);
  // Quiet start so the block sees no reading during reset
  initial
  begin
    rdValid = 1'b0;
    rdChan = 3'h0;
    rdValue = 32'h0000_0000;
    rdScanned = 1'b0;
    seqChan = 3'h0;
  end

  // Held across one rising edge; stale data inverted so it cannot pass for fresh
  task automatic send(input logic [2:0] ch, input logic [31:0] v, input logic sc);
    @(negedge clk_sys);
    seqChan = ch;
    rdChan = ch;
    rdValue = v;
    rdScanned = sc;
    rdValid = 1'b1;
    @(negedge clk_sys);
    rdValid = 1'b0;
    rdValue = ~v;
    rdChan = ~ch;
  endtask
endmodule
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam sale_pkg::sale_mode_t MN = sale_pkg::SALE_MODE_NONE;
  localparam sale_pkg::sale_mode_t MW = sale_pkg::SALE_MODE_WINDOW;
  localparam sale_pkg::sale_mode_t MU = sale_pkg::SALE_MODE_UPPER;
  localparam sale_pkg::sale_mode_t ML = sale_pkg::SALE_MODE_LOWER;
  localparam sale_pkg::sale_mode_t MO = sale_pkg::SALE_MODE_ON;
  localparam sale_pkg::sale_cond_t CP = sale_pkg::SALE_COND_PATTERN;
  localparam sale_pkg::sale_cond_t CN = sale_pkg::SALE_COND_NOT_PATTERN;
  localparam logic [31:0] Z = 32'h0000_0000;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic measWrite, measExternal, measFourWire, scaleEnable, alarmWrite, scanAdd, scanRemove;
  logic [2:0] measChan, scaleChan, alarmChan, scanChan, rdChan, seqChan, eventChan;
  sale_pkg::sale_kind_t measKind;
  sale_pkg::sale_width_t measWidth;
  sale_pkg::sale_mode_t alarmMode;
  sale_pkg::sale_cond_t alarmCond;
  logic [15:0] measDelay, connDelay;
  logic [1:0] alarmLineSel, eventLine;
  logic [31:0] alarmUpper, alarmLower, alarmPattern, alarmMask, rdValue, eventValue;
  logic rdValid, rdScanned, storeWrite, queueWrite, cfgAccept, cfgError, connFourWire;
  logic [3:0] alarmLine;
  logic [7:0] inScanMap;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;

  sale_evaluator u_sale_evaluator (.clk_sys, .rst_n, .measWrite, .measChan, .measKind, .measWidth,
    .measExternal, .measFourWire, .measDelay, .scaleEnable, .scaleChan, .alarmWrite, .alarmChan,
    .alarmMode, .alarmLineSel, .alarmCond, .alarmUpper, .alarmLower, .alarmPattern, .alarmMask,
    .scanAdd, .scanRemove, .scanChan, .rdValid, .rdChan, .rdValue, .rdScanned, .seqChan,
    .alarmLine, .storeWrite, .queueWrite, .eventChan, .eventValue, .eventLine, .cfgAccept,
    .cfgError, .connFourWire, .connDelay, .inScanMap);
  sale_seq_model u_sale_seq_model (.clk_sys, .rdValid, .rdChan, .rdValue, .rdScanned, .seqChan);

  // 125 MHz
  always #4 clk_sys = ~clk_sys;

  // Hang guard: whole run needs about a hundred cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Measurement setup; delay tracks the channel, odd channels four-wire, width from measWidth
  task automatic meas(input logic [2:0] ch, input sale_pkg::sale_kind_t k, input logic ext);
    @(negedge clk_sys);
    measChan = ch;
    measKind = k;
    measExternal = ext;
    measFourWire = ch[0];
    measDelay = {13'h0000, ch};
    measWrite = 1'b1;
    @(negedge clk_sys);
    measWrite = 1'b0;
  endtask

  // Alarm setup, answered exactly one cycle later
  task automatic al(input logic [2:0] ch, input sale_pkg::sale_mode_t m, input logic [1:0] ln,
    input sale_pkg::sale_cond_t c, input logic [31:0] up, input logic [31:0] lo, input logic [31:0] pat,
    input logic [31:0] mk, input logic ok);
    @(negedge clk_sys);
    alarmChan = ch;
    alarmMode = m;
    alarmLineSel = ln;
    alarmCond = c;
    alarmUpper = up;
    alarmLower = lo;
    alarmPattern = pat;
    alarmMask = mk;
    alarmWrite = 1'b1;
    @(negedge clk_sys);
    alarmWrite = 1'b0;
    check(cfgAccept, ok);
    check(cfgError, !ok);
  endtask

  task automatic scan(input logic [2:0] ch, input logic add);
    @(negedge clk_sys);
    scanChan = ch;
    scanAdd = add;
    scanRemove = !add;
    @(negedge clk_sys);
    scanAdd = 1'b0;
    scanRemove = 1'b0;
    check(inScanMap[ch], add);
  endtask

  // One reading; pulses and event fields checked in the answer cycle
  task automatic rd(input logic [2:0] ch, input logic [31:0] v, input logic sc, input logic [3:0] ln,
    input logic st);
    u_sale_seq_model.send(ch, v, sc);
    check(alarmLine, ln);
    check(queueWrite, |ln);
    check(storeWrite, st);
    if (|ln)
    begin
      check(eventChan, ch);
      check(eventValue, v);
      check(eventLine, {ln[3] | ln[2], ln[3] | ln[1]});
    end
  endtask

  // Main sequence
  initial
  begin
    {measWrite, measExternal, measFourWire, scaleEnable, alarmWrite, scanAdd, scanRemove} = 7'h00;
    {measChan, scaleChan, alarmChan, scanChan} = 12'h000;
    measKind = sale_pkg::SALE_KIND_MUX;
    measWidth = sale_pkg::SALE_WIDTH_8;
    alarmMode = MN;
    alarmCond = CN;
    measDelay = 16'h0000;
    alarmLineSel = 2'h0;
    {alarmUpper, alarmLower, alarmPattern, alarmMask} = {Z, Z, Z, Z};
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    check(alarmLine, Z);
    check(inScanMap, Z);
    scan(3'h1, 1'b1);
    al(3'h1, MW, 2'h0, CP, 32'h0000_0064, 32'hFFFF_FF9C, Z, Z, 1'b1);
    rd(3'h1, 32'h0000_0065, 1'b1, 4'h1, 1'b1);
    rd(3'h1, 32'h0000_0064, 1'b1, 4'h0, 1'b0);
    rd(3'h1, 32'hFFFF_FF9B, 1'b1, 4'h1, 1'b1);
    rd(3'h1, 32'hFFFF_FF9C, 1'b1, 4'h0, 1'b0);
    rd(3'h1, 32'hFFFF_FF9B, 1'b0, 4'h1, 1'b0);
    al(3'h1, MW, 2'h3, CP, 32'hFFFF_FF00, Z, Z, Z, 1'b0);
    rd(3'h1, 32'h0000_0065, 1'b1, 4'h1, 1'b1);
    al(3'h1, MO, 2'h0, CP, Z, Z, Z, Z, 1'b0);
    al(3'h1, MU, 2'h1, CP, 32'h0000_0031, Z, Z, Z, 1'b1);
    rd(3'h1, 32'h0000_0032, 1'b1, 4'h2, 1'b1);
    rd(3'h1, 32'h0000_0031, 1'b1, 4'h0, 1'b0);
    al(3'h1, ML, 2'h2, CP, Z, 32'hFFFF_FFFB, Z, Z, 1'b1);
    rd(3'h1, 32'hFFFF_FFFA, 1'b1, 4'h4, 1'b1);
    scan(3'h1, 1'b0);
    rd(3'h1, 32'hFFFF_FFFA, 1'b1, 4'h0, 1'b0);
    scan(3'h1, 1'b1);
    rd(3'h1, 32'hFFFF_FFFA, 1'b1, 4'h4, 1'b1);
    meas(3'h1, sale_pkg::SALE_KIND_MUX, 1'b0);
    rd(3'h1, 32'hFFFF_FFFA, 1'b1, 4'h0, 1'b0);
    al(3'h1, ML, 2'h2, CP, Z, 32'hFFFF_FFFB, Z, Z, 1'b1);
    @(negedge clk_sys);
    scaleChan = 3'h1;
    scaleEnable = 1'b1;
    @(negedge clk_sys);
    scaleEnable = 1'b0;
    rd(3'h1, 32'hFFFF_FFFA, 1'b1, 4'h0, 1'b0);
    al(3'h1, MN, 2'h0, CP, Z, Z, Z, Z, 1'b1);
    rd(3'h1, 32'hFFFF_FFFA, 1'b1, 4'h0, 1'b0);
    // Counter channel left out of the scan list on purpose
    meas(3'h2, sale_pkg::SALE_KIND_COUNTER, 1'b0);
    al(3'h2, ML, 2'h3, CP, Z, Z, Z, Z, 1'b0);
    al(3'h2, MU, 2'h3, CP, 32'hFFFF_FFFE, Z, Z, Z, 1'b1);
    rd(3'h2, 32'hFFFF_FFFF, 1'b0, 4'h8, 1'b0);
    rd(3'h2, 32'hFFFF_FFFE, 1'b0, 4'h0, 1'b0);
    rd(3'h2, 32'hFFFF_FFFF, 1'b1, 4'h8, 1'b1);
    check(connFourWire, 1'b0);
    check(connDelay, 32'h0000_0002);
    // Digital channel of 8 bits, low nibble ignored
    meas(3'h3, sale_pkg::SALE_KIND_DIGITAL, 1'b0);
    al(3'h3, MO, 2'h2, CP, Z, Z, 32'h0000_01A5, Z, 1'b0);
    al(3'h3, MU, 2'h2, CP, Z, Z, Z, Z, 1'b0);
    al(3'h3, MO, 2'h2, CP, Z, Z, 32'h0000_00A5, 32'h0000_000F, 1'b1);
    rd(3'h3, 32'h0000_00A0, 1'b1, 4'h4, 1'b0);
    rd(3'h3, 32'h0000_00B5, 1'b0, 4'h0, 1'b0);
    al(3'h3, MO, 2'h2, CN, Z, Z, 32'h0000_00A5, 32'h0000_000F, 1'b1);
    rd(3'h3, 32'h0000_00B5, 1'b0, 4'h4, 1'b0);
    rd(3'h3, 32'h0000_00A0, 1'b0, 4'h0, 1'b0);
    // Digital channel of 16 bits: bits above the width never compared
    measWidth = sale_pkg::SALE_WIDTH_16;
    meas(3'h4, sale_pkg::SALE_KIND_DIGITAL, 1'b0);
    al(3'h4, MO, 2'h1, CP, Z, Z, 32'h0001_A5A5, Z, 1'b0);
    al(3'h4, MO, 2'h1, CP, Z, Z, 32'h0000_A5A5, Z, 1'b1);
    rd(3'h4, 32'hFFFF_A5A5, 1'b1, 4'h2, 1'b0);
    rd(3'h4, 32'h0000_25A5, 1'b0, 4'h0, 1'b0);
    // External meter channel: connection setup only
    meas(3'h5, sale_pkg::SALE_KIND_MUX, 1'b1);
    al(3'h5, MU, 2'h0, CP, Z, Z, Z, Z, 1'b0);
    scan(3'h5, 1'b1);
    rd(3'h5, 32'h7FFF_FFFF, 1'b1, 4'h0, 1'b0);
    check(connFourWire, 1'b1);
    check(connDelay, 32'h0000_0005);
    print_verdict();
  end
endmodule
`default_nettype wire
